// >>> rtl/wdt_pkg.sv
package wdt_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] WDT_CNT_ADDR = 8'hD8;
  localparam logic [7:0] WDT_STAT_ADDR = 8'hDC;
  localparam logic [7:0] WDT_CNT_RESET = 8'hFE;
  // Reset value in counter order {soft reset, T5..T0}
  localparam logic [6:0] WDT_CNT_INIT = {WDT_CNT_RESET[1], WDT_CNT_RESET[2], WDT_CNT_RESET[3],
    WDT_CNT_RESET[4], WDT_CNT_RESET[5], WDT_CNT_RESET[6], WDT_CNT_RESET[7]};

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int WDT_ACT_BIT = 0;
  localparam int WDT_SR_BIT = 1;
  localparam int WDT_T_LO = 2;
  localparam int WDT_T_HI = 7;
  localparam int WDT_ST_ACTIVE = 0;
  localparam int WDT_ST_HW_OPT = 1;
  localparam int WDT_ST_EXT_OPT = 2;
  localparam int WDT_ST_STOP = 3;
  localparam int WDT_ST_PULSE = 4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int WDT_CLK_NS = 8;
  localparam int WDT_STEP_CYCLES = 3072;
  localparam int WDT_RST_PULSE_NS = 500;
  localparam int WDT_RST_PULSE_CYCLES = (WDT_RST_PULSE_NS + WDT_CLK_NS - 1) / WDT_CLK_NS;
  localparam logic [11:0] WDT_STEP_LAST = 12'(WDT_STEP_CYCLES - 1);
  localparam logic [6:0] WDT_PULSE_LAST = 7'(WDT_RST_PULSE_CYCLES - 1);

  typedef enum logic [1:0] {
    WDT_RUN,
    WDT_PULSE,
    WDT_STOPPED
  } wdt_state_e;

endpackage

// >>> rtl/wdt_top.sv
`timescale 1ns/1ns
module wdt_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Factory options, caught after reset release
  input wire logic activation_option,
  input wire logic external_stop_control_option,
  // Low power control
  input wire logic stop_req,
  input wire logic nmi_pin,
  input wire logic wake_req,
  output logic stop_as_wait,
  output logic stop_mode,
  // Reset pin, open drain
  output logic rst_pin_o,
  output logic rst_pin_oe
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic opt_taken_q;
  logic hw_act_q;
  logic ext_stop_q;
  logic act_q;
  logic [6:0] cnt_q;
  logic [11:0] div_q;
  logic [6:0] pulse_q;
  wdt_pkg::wdt_state_e state_q;
  logic ready_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic wait_q;
  logic access;
  logic wr_en;
  logic cnt_hit;
  logic step;
  logic frozen;
  logic fire;
  logic [7:0] cnt_view;
  logic [5:0] t_in;
  logic [31:0] rd_mux;
  logic rd_bad;
  logic act_d;
  logic [11:0] div_d;
  logic [6:0] cnt_d;
  wdt_pkg::wdt_state_e state_d;
  logic [6:0] pulse_d;
  logic wait_d;
  logic ready_d;
  logic [31:0] rdata_d;
  logic err_d;
  logic oe_q;
  logic stop_q;
  logic pin_lo_q;

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  // One wait state so that read data can come from a flip-flop
  assign access = psel & penable;
  assign wr_en = access & ready_q & pwrite & (paddr == wdt_pkg::WDT_CNT_ADDR);
  assign ready_d = access & ~ready_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  // ----------------------------------------
  // Option capture
  // ----------------------------------------
  // Straps are caught once, so a strap moving later cannot disarm the watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_taken_q <= 1'b0;
      hw_act_q <= 1'b0;
      ext_stop_q <= 1'b0;
    end else if (!opt_taken_q) begin
      opt_taken_q <= 1'b1;
      hw_act_q <= activation_option;
      ext_stop_q <= external_stop_control_option;
    end
  end

  // ----------------------------------------
  // Activation bit
  // ----------------------------------------
  // There is no path that clears the bit short of a reset
  always_comb begin
    act_d = act_q;
    if (!opt_taken_q) begin
      act_d = activation_option;
    end else if (hw_act_q) begin
      act_d = 1'b1;
    end else if (wr_en && pwdata[wdt_pkg::WDT_ACT_BIT]) begin
      act_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 1'b0;
    end else begin
      act_q <= act_d;
    end
  end

  // ----------------------------------------
  // Decrement divider
  // ----------------------------------------
  assign frozen = (state_q == wdt_pkg::WDT_STOPPED);
  assign cnt_hit = (div_q == wdt_pkg::WDT_STEP_LAST);
  assign step = cnt_hit & ~frozen;

  // A refresh restarts the interval, so it always buys full steps
  always_comb begin
    div_d = div_q;
    if (wr_en) begin
      div_d = '0;
    end else if (!frozen) begin
      div_d = cnt_hit ? '0 : div_q + 12'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Stored value is {soft reset, T5..T0}; the register shows T reversed
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      t_in[i] = pwdata[wdt_pkg::WDT_T_HI - i];
    end
  end

  // With the watchdog idle the value wraps from 00 to 7F as a free timer
  always_comb begin
    cnt_d = cnt_q;
    if (wr_en) begin
      cnt_d = {pwdata[wdt_pkg::WDT_SR_BIT], t_in};
    end else if (step) begin
      cnt_d = cnt_q - 7'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= wdt_pkg::WDT_CNT_INIT;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Reset cycle and stop control
  // ----------------------------------------
  // Soft-reset bit at zero while armed, by timeout or by a write
  assign fire = act_q & ~cnt_q[6];


  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // A soft-reset bit held low retriggers the pulse once it ends
  // Stop with the watchdog idle enters stop, and the counter freezes too
  always_comb begin
    state_d = state_q;
    pulse_d = pulse_q;
    wait_d = 1'b0;
    case (state_q)
      wdt_pkg::WDT_RUN: begin
        if (fire) begin
          state_d = wdt_pkg::WDT_PULSE;
          pulse_d = '0;
        end else if (stop_req) begin
          if (act_q && !(ext_stop_q && nmi_pin)) begin
            wait_d = 1'b1;
          end else begin
            state_d = wdt_pkg::WDT_STOPPED;
          end
        end
      end
      wdt_pkg::WDT_PULSE: begin
        if (pulse_q == wdt_pkg::WDT_PULSE_LAST) begin
          state_d = wdt_pkg::WDT_RUN;
        end else begin
          pulse_d = pulse_q + 7'd1;
        end
      end
      wdt_pkg::WDT_STOPPED: begin
        if (fire) begin
          state_d = wdt_pkg::WDT_PULSE;
          pulse_d = '0;
        end else if (wake_req) begin
          state_d = wdt_pkg::WDT_RUN;
        end
      end
      default: begin
        state_d = wdt_pkg::WDT_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= wdt_pkg::WDT_RUN;
      pulse_q <= '0;
      wait_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pulse_q <= pulse_d;
      wait_q <= wait_d;
    end
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  // Copies of the next state, so pins and flags come straight from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q <= 1'b0;
      stop_q <= 1'b0;
      pin_lo_q <= 1'b0;
    end else begin
      oe_q <= (state_d == wdt_pkg::WDT_PULSE);
      stop_q <= (state_d == wdt_pkg::WDT_STOPPED);
      pin_lo_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      cnt_view[wdt_pkg::WDT_T_HI - i] = cnt_q[i];
    end
    cnt_view[wdt_pkg::WDT_SR_BIT] = cnt_q[6];
    cnt_view[wdt_pkg::WDT_ACT_BIT] = act_q;
  end

  always_comb begin
    rd_mux = '0;
    rd_bad = 1'b0;
    if (paddr == wdt_pkg::WDT_CNT_ADDR) begin
      rd_mux[7:0] = cnt_view;
    end else if (paddr == wdt_pkg::WDT_STAT_ADDR) begin
      rd_mux[wdt_pkg::WDT_ST_ACTIVE] = act_q;
      rd_mux[wdt_pkg::WDT_ST_HW_OPT] = hw_act_q;
      rd_mux[wdt_pkg::WDT_ST_EXT_OPT] = ext_stop_q;
      rd_mux[wdt_pkg::WDT_ST_STOP] = frozen;
      rd_mux[wdt_pkg::WDT_ST_PULSE] = (state_q == wdt_pkg::WDT_PULSE);
    end else begin
      rd_bad = 1'b1;
    end
  end

  // Bit 0 of the counter view shows the real active state under either option
  always_comb begin
    rdata_d = '0;
    err_d = 1'b0;
    if (access && !ready_q) begin
      rdata_d = pwrite ? '0 : rd_mux;
      err_d = rd_bad | (pwrite & (paddr == wdt_pkg::WDT_STAT_ADDR));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign stop_as_wait = wait_q;
  assign stop_mode = stop_q;
  assign rst_pin_o = pin_lo_q;
  assign rst_pin_oe = oe_q;

endmodule

// >>> verification/wdt_props.sv
`timescale 1ns/1ns
module wdt_props (
  // Watched ports
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr, activation_option, external_stop_control_option,
  input wire logic stop_req, nmi_pin, wake_req, stop_as_wait, stop_mode, rst_pin_o, rst_pin_oe
);
  // ----------------------------------------
  // Reset pin pulse length
  // ----------------------------------------
  logic [6:0] oe_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      oe_cnt_q <= '0;
    else
      oe_cnt_q <= rst_pin_oe ? oe_cnt_q + 7'h01 : '0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside access");
  a_err_unmapped: assert property (
    pready && paddr != 8'hD8 && paddr != 8'hDC |-> pslverr) else $error("no slave error");
  a_rdata_idle: assert property (!pready |-> prdata == '0) else $error("stray read data");
  a_pin_low: assert property (rst_pin_o == 1'b0) else $error("pin value not low");
  a_pulse_end: assert property ($fell(rst_pin_oe) |-> oe_cnt_q == 7'h3F)
    else $error("reset pulse length");
  a_pulse_max: assert property (rst_pin_oe |-> oe_cnt_q < 7'h3F) else $error("pulse long");
  a_soft_fire: assert property (
    psel && penable && pready && pwrite && paddr == 8'hD8 && pwdata[1:0] == 2'b01
    |-> ##2 rst_pin_oe) else $error("no soft reset");
  a_wait_one: assert property (stop_as_wait |=> !stop_as_wait) else $error("wait long");
  a_stop_answer: assert property (
    stop_req && !stop_mode && !rst_pin_oe |=> stop_as_wait ^ stop_mode) else $error("stop");
  a_wake_exit: assert property (stop_mode && wake_req |=> !stop_mode) else $error("no wake");
endmodule

bind wdt_top wdt_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .activation_option(activation_option),
  .external_stop_control_option(external_stop_control_option), .stop_req(stop_req),
  .nmi_pin(nmi_pin), .wake_req(wake_req), .stop_as_wait(stop_as_wait),
  .stop_mode(stop_mode), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe));

// >>> verification/wdt_top_tb_top.sv
`timescale 1ns/1ns
module wdt_top_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic activation_option = 0, external_stop_control_option = 0;
  logic stop_req = 0, nmi_pin = 0, wake_req = 0, stop_as_wait, stop_mode, rst_pin_o, rst_pin_oe;
  int n_mismatch = 0, checked = 0;
  always #4 pclk = ~pclk;
  wdt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .activation_option(activation_option),
    .external_stop_control_option(external_stop_control_option), .stop_req(stop_req),
    .nmi_pin(nmi_pin), .wake_req(wake_req), .stop_as_wait(stop_as_wait),
    .stop_mode(stop_mode), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic rst(input logic hw, input logic ext);
    presetn <= 1'b0;
    activation_option <= hw;
    external_stop_control_option <= ext;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(0, 8'hD8, '0);
    chk(rd, 32'h0000_00FE);
    apb(0, 8'hD0, '0);
    chk(er, 1'b1);
    apb(1, 8'hDC, 32'h0000_0001);
    chk(er, 1'b1);
    apb(1, 8'hD8, 32'h0000_0002);
    repeat (3000) @(posedge pclk);
    apb(0, 8'hD8, '0);
    chk(rd, 32'h0000_0002);
    repeat (100) @(posedge pclk);
    apb(0, 8'hD8, '0);
    chk(rd, 32'h0000_00FC);
    chk(rst_pin_oe, 1'b0);
    apb(0, 8'hDC, '0);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic t_sw_fire();
    apb(1, 8'hD8, 32'h0000_00FF);
    apb(0, 8'hDC, '0);
    chk(rd[0], 1'b1);
    apb(1, 8'hD8, 32'h0000_00FE);
    apb(0, 8'hD8, '0);
    chk(rd, 32'h0000_00FF);
    apb(1, 8'hD8, 32'h0000_00FD);
    @(posedge pclk);
    #1 chk(rst_pin_oe, 1'b1);
    repeat (62) @(posedge pclk);
    #1 chk(rst_pin_oe, 1'b1);
    @(posedge pclk);
    #1 chk(rst_pin_oe, 1'b0);
    @(posedge pclk);
  endtask
  task automatic t_hw();
    rst(1, 0);
    apb(0, 8'hDC, '0);
    chk(rd, 32'h0000_0003);
    nmi_pin <= 1'b1;
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
    nmi_pin <= 1'b0;
    #1 chk(stop_as_wait, 1'b1);
    repeat (3) begin
      apb(1, 8'hD8, 32'h0000_0002);
      repeat (3000) @(posedge pclk);
      #1 chk(rst_pin_oe, 1'b0);
    end
    apb(1, 8'hD8, 32'h0000_0082);
    repeat (6144) @(posedge pclk);
    #1 chk(rst_pin_oe, 1'b0);
    @(posedge pclk);
    #1 chk(rst_pin_oe, 1'b1);
    @(posedge pclk);
  endtask
  task automatic t_stop();
    rst(1, 1);
    apb(0, 8'hDC, '0);
    chk(rd, 32'h0000_0007);
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
    #1 chk(stop_as_wait, 1'b1);
    @(posedge pclk);
    nmi_pin <= 1'b1;
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
    #1 chk(stop_mode, 1'b1);
    @(posedge pclk);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    #1 chk(stop_mode, 1'b0);
    @(posedge pclk);
  endtask
  initial begin
    rst(0, 0);
    t_regs();
    t_sw_fire();
    t_hw();
    t_stop();
    conclude();
  end
endmodule
